// ---- pbc_pkg.sv ----
package pbc_pkg;
    // register byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_TXPAT = 8'h04;
    localparam logic [7:0] ADR_RXPAT = 8'h08;
    localparam logic [7:0] ADR_SEED = 8'h0c;
    localparam logic [7:0] ADR_MEMLEN = 8'h10;
    localparam logic [7:0] ADR_MIXLEN = 8'h14;
    localparam logic [7:0] ADR_STATUS = 8'h18;
    localparam logic [7:0] ADR_ERRCNT = 8'h1c;
    localparam logic [7:0] ADR_BITCNT = 8'h20;
    localparam logic [1:0] ADR_MEM_PAGE = 2'h1;
    // control fields
    localparam int CTRL_TX_RUN = 0;
    localparam int CTRL_RX_RUN = 1;
    localparam int CTRL_TX_INV = 2;
    localparam int CTRL_RX_INV = 3;
    localparam int CTRL_CLR = 4;
    localparam int CTRL_RELOCK = 5;
    // pattern register: mode in [2:0], length select in [6:4]
    localparam int PAT_MODE_LSB = 0;
    localparam int PAT_LEN_LSB = 4;
    // reset values
    localparam logic [6:0] PAT_RESET = 7'h07;
    localparam logic [30:0] SEED_RESET = 31'h00000001;
    localparam logic [8:0] MEMLEN_RESET = 9'h01f;
    localparam logic [8:0] MIXLEN_RESET = 9'h0ff;
    // checker lock thresholds; fixed pattern last index; QRSS last and tap stages
    localparam logic [6:0] LOCK_RUN = 7'h40;
    localparam logic [9:0] WIN_LAST = 10'h3ff;
    localparam logic [6:0] ERR_LIMIT = 7'h40;
    localparam logic [8:0] FIXED_LAST = 9'h007;
    localparam logic [4:0] QRSS_LAST = 5'h13;
    localparam logic [4:0] QRSS_TAP = 5'h10;

    typedef enum logic [2:0] {
        MODE_PRBS, MODE_QRSS, MODE_ONES, MODE_ZEROS,
        MODE_ALT, MODE_MARK, MODE_MEM, MODE_MIX
    } pbc_mode_e;

    typedef enum logic [1:0] {LK_HUNT, LK_VERIFY, LK_LOCKED} pbc_lock_e;

    // length select 0..7 -> 4,8,9,11,15,20,23,31 stages; index of last stage
    function automatic logic [4:0] pbc_last(input logic [2:0] sel);
        case (sel)
            3'h0: return 5'h03;
            3'h1: return 5'h07;
            3'h2: return 5'h08;
            3'h3: return 5'h0a;
            3'h4: return 5'h0e;
            3'h5: return 5'h13;
            3'h6: return 5'h16;
            default: return 5'h1e;
        endcase
    endfunction : pbc_last

    // second feedback stage for each length
    function automatic logic [4:0] pbc_tap(input logic [2:0] sel);
        case (sel)
            3'h0: return 5'h02;
            3'h1: return 5'h05;
            3'h2: return 5'h04;
            3'h3: return 5'h08;
            3'h4: return 5'h0d;
            3'h5: return 5'h02;
            3'h6: return 5'h11;
            default: return 5'h1b;
        endcase
    endfunction : pbc_tap
endpackage : pbc_pkg

// ---- pbc_lfsr.sv ----
`timescale 1ns/100ps
`default_nettype none
module pbc_lfsr (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic step,
    input wire logic load,
    input wire logic [30:0] seed,
    input wire logic [2:0] len_sel,
    input wire logic qrss,
    input wire logic sync,
    input wire logic sync_bit,
    output logic bit_out
);
    logic [30:0] sreg;
    logic [30:0] next_sreg;
    logic [30:0] mask;
    logic [30:0] shifted;
    logic [4:0] last;
    logic [4:0] tap;
    logic fb;

    always_comb begin
        last = qrss ? pbc_pkg::QRSS_LAST : pbc_pkg::pbc_last(len_sel);
        tap = qrss ? pbc_pkg::QRSS_TAP : pbc_pkg::pbc_tap(len_sel);
        for (int k = 0; k < 31; k++) begin
            mask[k] = (5'(k) <= last);
        end
        fb = sreg[last] ^ sreg[tap];
        // eight stages need four taps (8,6,5,4) to reach the full period
        if (!qrss && len_sel == 3'h1) begin
            fb = fb ^ sreg[4] ^ sreg[3];
        end
        // zero suppression caps zero runs at fourteen
        bit_out = fb | (qrss & ~|sreg[13:0]);
        shifted = {sreg[29:0], sync ? sync_bit : fb} & mask;
        next_sreg = sreg;
        if (load) begin
            next_sreg = seed & mask;
        end else if (step) begin
            next_sreg = shifted;
        end
        // never allowed to rest in the all-zero state
        if (~|next_sreg) begin
            next_sreg = pbc_pkg::SEED_RESET;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sreg <= pbc_pkg::SEED_RESET;
        end else if (ce) begin
            sreg <= next_sreg;
        end
    end

    state_nonzero_a: assert property (@(posedge core_clk) disable iff (!rstn)
        sreg != 31'h0) else $error("generator register reached zero");
    four_stage_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && step && !load && !sync && !qrss && len_sel == 3'h0
        && (sreg[2] | sreg[1] | sreg[0] | (sreg[2] ^ sreg[3]))
        |=> sreg[3:0] == {$past(sreg[2:0]), $past(sreg[2] ^ sreg[3])})
        else $error("four-stage shift wrong");
endmodule : pbc_lfsr
`default_nettype wire

// ---- pbc_mem.sv ----
`timescale 1ns/100ps
`default_nettype none
module pbc_mem (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [31:0] wr_mask,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] rd_idx,
    output logic [31:0] rd_word,
    input wire logic [8:0] bit_idx_a,
    input wire logic [8:0] bit_idx_b,
    output logic bit_a,
    output logic bit_b
);
    logic [31:0] words [16];
    logic [31:0] next_word;

    // user pattern, sent lsb of word 0 first
    always_comb begin
        next_word = (words[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
        rd_word = words[rd_idx];
        bit_a = words[bit_idx_a[8:5]][bit_idx_a[4:0]];
        bit_b = words[bit_idx_b[8:5]][bit_idx_b[4:0]];
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < 16; k++) begin
                words[k] <= 32'h0;
            end
        end else if (ce && wr_en) begin
            words[wr_idx] <= next_word;
        end
    end
endmodule : pbc_mem
`default_nettype wire

// ---- pbc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module pbc_top (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic tx_data,
    output logic tx_valid,
    input wire logic rx_data,
    input wire logic rx_valid,
    output logic locked
);
    ////////////////////////////////////////////////////////////////////////
    logic tx_run, rx_run, tx_inv, rx_inv, ack;
    logic next_tx_run, next_rx_run, next_tx_inv, next_rx_inv, next_ack;
    logic [6:0] tx_pat, rx_pat, next_tx_pat, next_rx_pat;
    logic [30:0] seed, next_seed;
    logic [8:0] mem_len, mix_len, next_mem_len, next_mix_len;
    logic [31:0] rdata, next_rdata, wmask, mem_word;
    logic wr, rd, clr, relock, mem_wr;
    logic [31:0] err_cnt, bit_cnt;
    pbc_pkg::pbc_lock_e lk;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] m,
                                          input logic [31:0] d);
        return (old & ~m) | (d & m);
    endfunction : merge

    always_comb begin
        wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack;
        rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack;
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        next_ack = wb_cyc_i & wb_stb_i & ~ack;
        next_tx_run = tx_run;
        next_rx_run = rx_run;
        next_tx_inv = tx_inv;
        next_rx_inv = rx_inv;
        next_tx_pat = tx_pat;
        next_rx_pat = rx_pat;
        next_seed = seed;
        next_mem_len = mem_len;
        next_mix_len = mix_len;
        clr = 1'b0;
        relock = 1'b0;
        mem_wr = wr && wb_adr_i[7:6] == pbc_pkg::ADR_MEM_PAGE;
        if (wr && wb_sel_i[0]) begin
            case (wb_adr_i)
                pbc_pkg::ADR_CTRL: begin
                    next_tx_run = wb_dat_i[pbc_pkg::CTRL_TX_RUN];
                    next_rx_run = wb_dat_i[pbc_pkg::CTRL_RX_RUN];
                    next_tx_inv = wb_dat_i[pbc_pkg::CTRL_TX_INV];
                    next_rx_inv = wb_dat_i[pbc_pkg::CTRL_RX_INV];
                    clr = wb_dat_i[pbc_pkg::CTRL_CLR];
                    relock = wb_dat_i[pbc_pkg::CTRL_RELOCK];
                end
                pbc_pkg::ADR_TXPAT: next_tx_pat = wb_dat_i[6:0];
                pbc_pkg::ADR_RXPAT: next_rx_pat = wb_dat_i[6:0];
                default: begin
                end
            endcase
        end
        if (wr) begin
            case (wb_adr_i)
                pbc_pkg::ADR_SEED:
                    next_seed = 31'(merge({1'b0, seed}, wmask, wb_dat_i));
                pbc_pkg::ADR_MEMLEN:
                    next_mem_len = 9'(merge({23'h0, mem_len}, wmask,
                                            wb_dat_i));
                pbc_pkg::ADR_MIXLEN:
                    next_mix_len = 9'(merge({23'h0, mix_len}, wmask,
                                            wb_dat_i));
                default: begin
                end
            endcase
        end
        next_rdata = rdata;
        if (rd) begin
            case (wb_adr_i)
                pbc_pkg::ADR_CTRL:
                    next_rdata = {28'h0, rx_inv, tx_inv, rx_run, tx_run};
                pbc_pkg::ADR_TXPAT: next_rdata = {25'h0, tx_pat};
                pbc_pkg::ADR_RXPAT: next_rdata = {25'h0, rx_pat};
                pbc_pkg::ADR_SEED: next_rdata = {1'b0, seed};
                pbc_pkg::ADR_MEMLEN: next_rdata = {23'h0, mem_len};
                pbc_pkg::ADR_MIXLEN: next_rdata = {23'h0, mix_len};
                pbc_pkg::ADR_STATUS: next_rdata = {29'h0, lk, locked};
                pbc_pkg::ADR_ERRCNT: next_rdata = err_cnt;
                pbc_pkg::ADR_BITCNT: next_rdata = bit_cnt;
                default: next_rdata = (wb_adr_i[7:6] == pbc_pkg::ADR_MEM_PAGE)
                                      ? mem_word : 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
            rdata <= 32'h0;
            tx_run <= 1'b0;
            rx_run <= 1'b0;
            tx_inv <= 1'b0;
            rx_inv <= 1'b0;
            tx_pat <= pbc_pkg::PAT_RESET;
            rx_pat <= pbc_pkg::PAT_RESET;
            seed <= pbc_pkg::SEED_RESET;
            mem_len <= pbc_pkg::MEMLEN_RESET;
            mix_len <= pbc_pkg::MIXLEN_RESET;
        end else if (ce) begin
            ack <= next_ack;
            rdata <= next_rdata;
            tx_run <= next_tx_run;
            rx_run <= next_rx_run;
            tx_inv <= next_tx_inv;
            rx_inv <= next_rx_inv;
            tx_pat <= next_tx_pat;
            rx_pat <= next_rx_pat;
            seed <= next_seed;
            mem_len <= next_mem_len;
            mix_len <= next_mix_len;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

    ////////////////////////////////////////////////////////////////////////
    // channel 0 builds the transmit pattern, channel 1 the expected one
    logic [1:0] ch_step, ch_load, ch_sync, ch_bit, mem_bit;
    logic [8:0] ch_idx [2];
    logic [6:0] ch_pat [2];

    assign ch_pat[0] = tx_pat;
    assign ch_pat[1] = rx_pat;

    pbc_mem u_mem (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .wr_en(mem_wr),
        .wr_idx(wb_adr_i[5:2]),
        .wr_mask(wmask),
        .wr_data(wb_dat_i),
        .rd_idx(wb_adr_i[5:2]),
        .rd_word(mem_word),
        .bit_idx_a(ch_idx[0]),
        .bit_idx_b(ch_idx[1]),
        .bit_a(mem_bit[0]),
        .bit_b(mem_bit[1])
    );

    for (genvar i = 0; i < 2; i++) begin : g_ch
        pbc_pkg::pbc_mode_e mode;
        logic [8:0] idx, next_idx, lim;
        logic seg, next_seg, prbs_on, prbs_bit;

        always_comb begin
            mode = pbc_pkg::pbc_mode_e'(ch_pat[i][pbc_pkg::PAT_MODE_LSB +: 3]);
            lim = (mode == pbc_pkg::MODE_MEM) ? mem_len
                : (mode == pbc_pkg::MODE_MIX) ? (seg ? mix_len : mem_len)
                : pbc_pkg::FIXED_LAST;
            prbs_on = mode == pbc_pkg::MODE_PRBS || mode == pbc_pkg::MODE_QRSS
                      || (mode == pbc_pkg::MODE_MIX && seg);
            next_idx = idx;
            next_seg = seg;
            if (ch_load[i]) begin
                next_idx = 9'h0;
                next_seg = 1'b0;
            end else if (ch_step[i]) begin
                next_idx = (idx >= lim) ? 9'h0 : idx + 9'h1;
                if (idx >= lim && mode == pbc_pkg::MODE_MIX) begin
                    next_seg = ~seg;
                end
            end
            case (mode)
                pbc_pkg::MODE_ONES: ch_bit[i] = 1'b1;
                pbc_pkg::MODE_ZEROS: ch_bit[i] = 1'b0;
                pbc_pkg::MODE_ALT: ch_bit[i] = ~idx[0];
                pbc_pkg::MODE_MARK: ch_bit[i] = (idx[2:0] == 3'h0);
                pbc_pkg::MODE_MEM: ch_bit[i] = mem_bit[i];
                pbc_pkg::MODE_MIX: ch_bit[i] = seg ? prbs_bit : mem_bit[i];
                default: ch_bit[i] = prbs_bit;
            endcase
        end

        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                idx <= 9'h0;
                seg <= 1'b0;
            end else if (ce) begin
                idx <= next_idx;
                seg <= next_seg;
            end
        end

        assign ch_idx[i] = idx;

        pbc_lfsr u_lfsr (
            .core_clk(core_clk),
            .rstn(rstn),
            .ce(ce),
            .step(ch_step[i] & prbs_on),
            .load(ch_load[i]),
            .seed(seed),
            .len_sel(ch_pat[i][pbc_pkg::PAT_LEN_LSB +: 3]),
            .qrss(mode == pbc_pkg::MODE_QRSS),
            .sync(ch_sync[i]),
            .sync_bit(rx_data ^ rx_inv),
            .bit_out(prbs_bit)
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit: seed reloaded while stopped, one bit per enabled cycle
    logic next_tx_data;

    always_comb begin
        ch_load[0] = ~tx_run;
        ch_step[0] = tx_run;
        ch_sync[0] = 1'b0;
        next_tx_data = tx_run ? (ch_bit[0] ^ tx_inv) : 1'b0;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_data <= 1'b0;
            tx_valid <= 1'b0;
        end else if (ce) begin
            tx_data <= next_tx_data;
            tx_valid <= tx_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checker: align, verify a clean run, then count
    pbc_pkg::pbc_lock_e next_lk;
    logic [6:0] run, next_run, win_err, next_win_err;
    logic [9:0] win, next_win;
    logic [31:0] next_err_cnt, next_bit_cnt;
    logic [4:0] rx_last;
    logic rx_prbs, expect_bit, miss, slip;

    always_comb begin
        rx_last = pbc_pkg::pbc_last(rx_pat[pbc_pkg::PAT_LEN_LSB +: 3]);
        if (rx_pat[2:0] == 3'(pbc_pkg::MODE_QRSS)) begin
            rx_last = pbc_pkg::QRSS_LAST;
        end
        rx_prbs = rx_pat[2:0] == 3'(pbc_pkg::MODE_PRBS)
                  || rx_pat[2:0] == 3'(pbc_pkg::MODE_QRSS);
        expect_bit = ch_bit[1] ^ rx_inv;
        miss = rx_data ^ expect_bit;
        // fixed data aligns by holding the expected pattern back one bit
        slip = rx_valid && miss && !rx_prbs && lk != pbc_pkg::LK_LOCKED;
        ch_sync[1] = rx_prbs && lk == pbc_pkg::LK_HUNT;
        ch_load[1] = ~rx_run;
        ch_step[1] = rx_run & rx_valid & ~slip;
        next_lk = lk;
        next_run = run;
        next_win = win;
        next_win_err = win_err;
        case (lk)
            pbc_pkg::LK_HUNT: begin
                if (!rx_prbs) begin
                    next_lk = pbc_pkg::LK_VERIFY;
                    next_run = 7'h0;
                end else if (rx_valid) begin
                    next_run = run + 7'h1;
                    if (run[4:0] >= rx_last) begin
                        next_lk = pbc_pkg::LK_VERIFY;
                        next_run = 7'h0;
                    end
                end
            end
            pbc_pkg::LK_VERIFY: begin
                if (rx_valid) begin
                    next_run = miss ? 7'h0 : run + 7'h1;
                    if (miss && rx_prbs) begin
                        next_lk = pbc_pkg::LK_HUNT;
                    end else if (!miss && run + 7'h1 >= pbc_pkg::LOCK_RUN) begin
                        next_lk = pbc_pkg::LK_LOCKED;
                        next_win = 10'h0;
                        next_win_err = 7'h0;
                    end
                end
            end
            pbc_pkg::LK_LOCKED: begin
                if (rx_valid) begin
                    next_win = win + 10'h1;
                    next_win_err = win_err + {6'h0, miss};
                    if (next_win_err >= pbc_pkg::ERR_LIMIT) begin
                        next_lk = pbc_pkg::LK_HUNT;
                        next_run = 7'h0;
                    end else if (win == pbc_pkg::WIN_LAST) begin
                        next_win_err = 7'h0;
                    end
                end
            end
            default: next_lk = pbc_pkg::LK_HUNT;
        endcase
        if (!rx_run || relock) begin
            next_lk = pbc_pkg::LK_HUNT;
            next_run = 7'h0;
        end
        // counters saturate; a clear still keeps the bit of its own cycle
        next_err_cnt = clr ? 32'h0 : err_cnt;
        next_bit_cnt = clr ? 32'h0 : bit_cnt;
        if (lk == pbc_pkg::LK_LOCKED && rx_valid) begin
            if (~&next_bit_cnt) begin
                next_bit_cnt = next_bit_cnt + 32'h1;
            end
            if (miss && ~&next_err_cnt) begin
                next_err_cnt = next_err_cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lk <= pbc_pkg::LK_HUNT;
            run <= 7'h0;
            win <= 10'h0;
            win_err <= 7'h0;
            err_cnt <= 32'h0;
            bit_cnt <= 32'h0;
        end else if (ce) begin
            lk <= next_lk;
            run <= next_run;
            win <= next_win;
            win_err <= next_win_err;
            err_cnt <= next_err_cnt;
            bit_cnt <= next_bit_cnt;
        end
    end

    assign locked = (lk == pbc_pkg::LK_LOCKED);

    ////////////////////////////////////////////////////////////////////////
    sequence s_locked_err;
        ce && locked && rx_valid && miss && !clr && ~&err_cnt;
    endsequence

    tx_polarity_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && tx_run |=> tx_data == $past(ch_bit[0] ^ tx_inv))
        else $error("tx bit polarity wrong");
    fixed_ones_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && tx_run && !tx_inv && tx_pat[2:0] == 3'(pbc_pkg::MODE_ONES)
        |=> tx_data) else $error("ones pattern broken");
    err_count_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_locked_err |=> err_cnt == $past(err_cnt) + 32'h1)
        else $error("mismatch not counted");
    bit_count_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && locked && rx_valid && !clr && ~&bit_cnt
        |=> bit_cnt == $past(bit_cnt) + 32'h1)
        else $error("compared bit not counted");
    unlocked_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && !locked && !clr |=> $stable(err_cnt) && $stable(bit_cnt))
        else $error("counted before lock");
    lock_entry_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(locked) |-> $past(run) == pbc_pkg::LOCK_RUN - 7'h1)
        else $error("locked without clean run");
    relock_go_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && relock |=> lk == pbc_pkg::LK_HUNT)
        else $error("relock ignored");
    wb_ack_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && wb_cyc_i && wb_stb_i && !ack |=> ack ##1 !ack)
        else $error("bus answer timing wrong");
endmodule : pbc_top
`default_nettype wire

// ---- pbc_sut.sv ----
`timescale 1ns/100ps
`default_nettype none
module pbc_sut (
    input wire logic core_clk,
    input wire logic din,
    input wire logic din_valid,
    input wire logic flip,
    output logic dout,
    output logic dout_valid
);
    // idle line toggles so a stale bit never passes as data
    always_ff @(posedge core_clk) begin
        dout <= din_valid ? din ^ flip : ~dout;
        dout_valid <= din_valid;
    end
endmodule : pbc_sut
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic flip = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rs = 32'h00017067;
    logic [31:0] rdat;
    logic ack, txd, txv, rxd, rxv, lk;
    logic cap [1024];
    logic [31:0] exp_q [$];
    int fails = 0;
    int checked = 0;
    initial forever #12.5 core_clk = ~core_clk;
    pbc_top pbc_top_inst (.core_clk(core_clk), .rstn(rstn), .ce(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tx_data(txd), .tx_valid(txv), .rx_data(rxd), .rx_valid(rxv),
        .locked(lk));
    pbc_sut pbc_sut_inst (.core_clk(core_clk), .din(txd), .din_valid(txv),
        .flip(flip), .dout(rxd), .dout_valid(rxv));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd
    function automatic logic [31:0] pk(input int n);
        logic [31:0] v = 32'h0;
        for (int i = 0; i < n; i++) v[i] = cap[i];
        return v;
    endfunction : pk
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        checked++;
        if (e !== s) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
            fails++;
        end
    endtask : chk
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        @(posedge core_clk);
        for (int n = 0; n < 50 && ack !== 1'b1; n++) @(posedge core_clk);
        chk("ack", 1'b1, ack);
        if (ack !== 1'b1) complete_run();
        cyc <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask : rd
    // read data is judged against the oldest note
    always @(posedge core_clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            chk("rdat", exp_q.pop_front(), rdat);
        end
    end
    task automatic grab(input int nb);
        for (int i = 0; i < nb; i++) begin
            @(negedge core_clk);
            cap[i] = txd;
        end
        chk("tx_valid", 1'b1, txv);
    endtask : grab
    task automatic wl(input logic e);
        for (int n = 0; n < 600 && lk !== 1'b1; n++) @(negedge core_clk);
        chk("locked", e, lk);
        if (e === 1'b1 && lk !== 1'b1) complete_run();
    endtask : wl
    task automatic prd(input logic [2:0] ln, input logic inv,
        input logic [31:0] sd, input int p, input int on, input int zr);
        int ones = 0;
        int bad = 0;
        int run = 0;
        int mx = 0;
        wr(pbc_pkg::ADR_CTRL, 32'h0);
        wr(pbc_pkg::ADR_SEED, sd);
        wr(pbc_pkg::ADR_TXPAT, {25'h0, ln, 4'h0});
        wr(pbc_pkg::ADR_CTRL, {29'h0, inv, 2'h1});
        grab(2 * p);
        for (int i = 0; i < 2 * p; i++) begin
            run = cap[i] ? 0 : run + 1;
            mx = run > mx ? run : mx;
            if (i < p) ones += cap[i];
            if (i < p) bad += (cap[i] !== cap[i + p]);
        end
        chk("period", 0, bad);
        chk("ones", on, ones);
        chk("zero_run", zr, mx);
        $display("prbs length test done");
    endtask : prd
    task automatic complete_run();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int ot [4];
        logic [31:0] w;
        ot = '{16, 0, 8, 2};
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd(pbc_pkg::ADR_SEED, 32'h1);
        rd(pbc_pkg::ADR_MIXLEN, 32'hff);
        rd(8'h3c, 32'h0);
        prd(3'h0, 1'b0, rnd() | 32'h1, 15, 8, 3);
        prd(3'h0, 1'b1, 32'h0, 15, 7, 4);
        prd(3'h1, 1'b0, rnd() | 32'h1, 255, 128, 7);
        prd(3'h2, 1'b1, rnd() | 32'h1, 511, 255, 9);
        w = rnd();
        wr(8'h40, w);
        for (int m = 2; m < 7; m++) begin
            wr(pbc_pkg::ADR_CTRL, 32'h0);
            wr(pbc_pkg::ADR_TXPAT, m);
            wr(pbc_pkg::ADR_CTRL, 32'h1);
            grab(16);
            // bit 0 has gone out before the control write returns
            if (m == 6) chk("mem", w[16:1], pk(16));
            else chk("fixed", ot[m - 2], $countones(pk(16)));
        end
        $display("fixed and memory test done");
        wr(pbc_pkg::ADR_CTRL, 32'h0);
        wr(pbc_pkg::ADR_TXPAT, 32'h10);
        wr(pbc_pkg::ADR_RXPAT, 32'h10);
        wr(pbc_pkg::ADR_CTRL, 32'h3);
        wl(1'b1);
        wr(pbc_pkg::ADR_CTRL, 32'h13);
        rd(pbc_pkg::ADR_ERRCNT, 32'h0);
        flip <= 1'b1;
        @(posedge core_clk);
        flip <= 1'b0;
        @(posedge core_clk);
        rd(pbc_pkg::ADR_ERRCNT, 32'h1);
        rd(pbc_pkg::ADR_STATUS, 32'h5);
        wr(pbc_pkg::ADR_CTRL, 32'h2b);
        wl(1'b0);
        wr(pbc_pkg::ADR_CTRL, 32'h0);
        wr(pbc_pkg::ADR_TXPAT, 32'h2);
        wr(pbc_pkg::ADR_RXPAT, 32'h3);
        wr(pbc_pkg::ADR_CTRL, 32'h2b);
        wl(1'b1);
        chk("notes", 0, exp_q.size());
        $display("checker test done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
